// ### src/bps_defs.svh
// Purpose: Constants for the battery pack supervisor
// Assumes: 20 MHz core clock
// Notes:   Times kept in their own units; cycle counts derived
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

`define BPS_CLK_PERIOD_NS   50
`define BPS_TICK_MS         1
`define BPS_TICK_CYCLES     ((`BPS_TICK_MS * 1000000) / `BPS_CLK_PERIOD_NS)
`define BPS_WORK_MS         250
`define BPS_PRESENT_MS      1000
`define BPS_SECOND_MS       1000
`define BPS_BUSOFF_MS       2000
`define BPS_BUS_RESUME_MS   1
`define BPS_DEBOUNCE_MS     10
`define BPS_LOG_SLOW_HOURS  10
`define BPS_LOG_FAST_HOURS  2
`define BPS_LOG_SLOW_S      (`BPS_LOG_SLOW_HOURS * 3600)
`define BPS_LOG_FAST_S      (`BPS_LOG_FAST_HOURS * 3600)

`define BPS_REG_CTRL        8'h00
`define BPS_REG_STATUS      8'h01
`define BPS_REG_SLEEP_INT   8'h02
`define BPS_REG_EOFF_TMO    8'h03
`define BPS_REG_TRIP_SET    8'h04
`define BPS_REG_TRIP_CLR    8'h05
`define BPS_REG_OP_STATE    8'h06
`define BPS_REG_BALANCE     8'h07
`define BPS_REG_TEMP_CFG    8'h08
`define BPS_REG_COUL_LO     8'h09
`define BPS_REG_COUL_HI     8'h0a

`define BPS_CTRL_MODE_LSB   0
`define BPS_CTRL_CHG_BIT    2
`define BPS_CTRL_DSG_BIT    3
`define BPS_CTRL_EXTBAL_BIT 4
`define BPS_CTRL_TRIP_BIT   5
`define BPS_CTRL_SEG_LSB    8
`define BPS_OPST_TRIP_BIT   0

`define BPS_CTRL_RESET      16'h030c
`define BPS_SLEEP_RESET     16'h0014
`define BPS_EOFF_RESET      16'h003c
`define BPS_TRIP_SET_RESET  16'h00c8
`define BPS_TRIP_CLR_RESET  16'h012c
`define BPS_TEMP_RESET      16'h0001

`endif

// ### src/bps_pkg.sv
// Purpose: Types for the battery pack supervisor
// Assumes: Constants come from bps_defs.svh
// Notes:   All state of the top module is one packed struct
package bps_pkg;

	typedef enum logic [1:0] {
		BPS_NORMAL   = 2'b00,
		BPS_SLEEP    = 2'b01,
		BPS_SHUTDOWN = 2'b10
	} bps_mode_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bps_bus_req_type;

	typedef struct packed {
		logic        work_start;
		logic        cell_refresh;
		logic        low_power;
		logic        log_write_slow;
		logic        log_write_fast;
	} bps_sched_type;

	typedef struct packed {
		logic [1:0]   system_present_n_s;
		logic [1:0]   btn_s;
		logic [1:0]   bclk_s;
		logic [1:0]   bdat_s;
		logic         btn_stable;
		logic [3:0]   btn_cnt;
		logic [14:0]  tick_cnt;
		logic [7:0]   work_cnt;
		logic [9:0]   sec_cnt;
		logic [15:0]  slow_cnt;
		logic [12:0]  fast_cnt;
		logic [15:0]  sleep_cnt;
		logic [15:0]  eoff_cnt;
		logic [10:0]  busoff_cnt;
		bps_mode_type mode;
		logic         present;
		logic         eoff;
		logic         busoff;
		logic         fuse;
		logic         trip;
		logic [15:0]  ctrl;
		logic [15:0]  sleep_int;
		logic [15:0]  eoff_tmo;
		logic [15:0]  trip_set;
		logic [15:0]  trip_clr;
		logic [3:0]   bal_req;
		logic [15:0]  temp_cfg;
		logic [31:0]  coul;
		logic         charging;
		logic         discharging;
		logic [15:0]  rdata;
		bps_sched_type sched;
		logic [4:0]   seg;
	} bps_state_type;

endpackage : bps_pkg

// ### src/bps_supervisor.sv
// Purpose: Supervisory control of a battery pack manager
// Assumes: Single 20 MHz clock, registers on a plain strobe port
// Notes:   All slow rates derive from a 1 ms enable pulse
`include "bps_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module bps_supervisor #(
	parameter int TICK_CYCLES = `BPS_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	// Register port
	input  wire bps_pkg::bps_bus_req_type bus_req,
	output logic [15:0]                 bus_rdata,
	// Pack pins
	input  wire logic                   system_present_n,
	input  wire logic                   emergency_off_button,
	input  wire logic                   bus_clock_pin,
	input  wire logic                   bus_data_pin,
	output logic                        charge_switch_drive,
	output logic                        discharge_switch_drive,
	output logic                        trip_point_irq,
	output logic                        trip_point_pullup_en,
	output logic                        fuse_fire,
	output logic [4:0]                  display_seg,
	// Measurement side
	input  wire logic signed [15:0]     sense_current,
	input  wire logic                   sense_valid,
	input  wire logic [15:0]            remaining_charge,
	input  wire logic [6:0]             relative_charge_percent,
	input  wire logic                   permanent_fail,
	input  wire logic [4:0]             permanent_fail_code,
	input  wire logic                   fault_detected,
	input  wire logic                   secondary_fault,
	input  wire logic [15:0]            log_ram_sig,
	input  wire logic [15:0]            log_nv_sig,
	input  wire logic [15:0]            log_fast_ram_sig,
	input  wire logic [15:0]            log_fast_nv_sig,
	// Control outputs
	output bps_pkg::bps_sched_type      sched,
	output logic                        bus_ready,
	output logic [3:0]                  balance_en,
	output logic [4:0]                  temp_enable,
	output logic [4:0]                  temp_is_switch
);

	// Keeps only the lowest requested cell
	function automatic logic [3:0] bps_lowest(input logic [3:0] r);
		bps_lowest = r & (~r + 4'h1);
	endfunction : bps_lowest

	// Segments lit for a charge percentage on n segments
	function automatic logic [4:0] bps_bar(input logic [6:0] pct, input logic [2:0] n);
		logic [4:0] b;
		b = 5'h00;
		for (int k = 0; k < 5; k++) begin
			if (k < int'(n) && int'(pct) * int'(n) > k * 100)
				b[k] = 1'b1;
		end
		bps_bar = b;
	endfunction : bps_bar

	// Out-of-range counts fall back to the nearest legal display
	function automatic logic [2:0] bps_seg_count(input logic [2:0] f);
		if (f < 3'h3)
			bps_seg_count = 3'h3;
		else if (f > 3'h5)
			bps_seg_count = 3'h5;
		else
			bps_seg_count = f;
	endfunction : bps_seg_count

	bps_pkg::bps_state_type s_q;
	bps_pkg::bps_state_type s_d;

	logic tick;
	logic btn_fall;
	logic sec_tick;
	logic active;
	logic [2:0] seg_n;

	assign tick   = (s_q.tick_cnt == 15'(TICK_CYCLES - 1));
	assign active = (s_q.mode != bps_pkg::BPS_SHUTDOWN);
	assign seg_n  = bps_seg_count(s_q.ctrl[`BPS_CTRL_SEG_LSB +: 3]);

	always_comb begin
		s_d = s_q;
		s_d.sched = '0;
		btn_fall = 1'b0;
		sec_tick = 1'b0;

		// Pins pass two flops before use
		s_d.system_present_n_s = {s_q.system_present_n_s[0], system_present_n};
		s_d.btn_s  = {s_q.btn_s[0], emergency_off_button};
		s_d.bclk_s = {s_q.bclk_s[0], bus_clock_pin};
		s_d.bdat_s = {s_q.bdat_s[0], bus_data_pin};

		// 1 ms base tick
		s_d.tick_cnt = tick ? 15'h0000 : s_q.tick_cnt + 15'h0001;

		// Level must hold the debounce time before it counts
		if (s_q.btn_s[1] == s_q.btn_stable) begin
			s_d.btn_cnt = 4'h0;
		end else if (tick) begin
			if (s_q.btn_cnt == 4'(`BPS_DEBOUNCE_MS - 1)) begin
				s_d.btn_stable = s_q.btn_s[1];
				s_d.btn_cnt = 4'h0;
				btn_fall = s_q.btn_stable;
			end else begin
				s_d.btn_cnt = s_q.btn_cnt + 4'h1;
			end
		end

		// Second counter and long log periods
		if (tick) begin
			if (s_q.sec_cnt == 10'(`BPS_SECOND_MS - 1)) begin
				s_d.sec_cnt = 10'h000;
				sec_tick = 1'b1;
			end else begin
				s_d.sec_cnt = s_q.sec_cnt + 10'h001;
			end
		end
		if (sec_tick) begin
			s_d.present = ~s_q.system_present_n_s[1];
			if (s_q.slow_cnt == 16'(`BPS_LOG_SLOW_S - 1)) begin
				s_d.slow_cnt = 16'h0000;
				s_d.sched.log_write_slow = active && (log_ram_sig != log_nv_sig);
			end else begin
				s_d.slow_cnt = s_q.slow_cnt + 16'h0001;
			end
			if (s_q.fast_cnt == 13'(`BPS_LOG_FAST_S - 1)) begin
				s_d.fast_cnt = 13'h0000;
				s_d.sched.log_write_fast = active && (log_fast_ram_sig != log_fast_nv_sig);
			end else begin
				s_d.fast_cnt = s_q.fast_cnt + 13'h0001;
			end
		end

		// Quarter-second work slot
		if (tick) begin
			if (s_q.work_cnt == 8'(`BPS_WORK_MS - 1)) begin
				s_d.work_cnt = 8'h00;
				if (s_q.mode == bps_pkg::BPS_NORMAL) begin
					s_d.sched.work_start = 1'b1;
					s_d.sched.cell_refresh = 1'b1;
				end else if (s_q.mode == bps_pkg::BPS_SLEEP) begin
					if (s_q.sleep_cnt + 16'h0001 >= s_q.sleep_int) begin
						s_d.sleep_cnt = 16'h0000;
						s_d.sched.work_start = 1'b1;
						s_d.sched.cell_refresh = 1'b1;
					end else begin
						s_d.sleep_cnt = s_q.sleep_cnt + 16'h0001;
					end
				end
			end else begin
				s_d.work_cnt = s_q.work_cnt + 8'h01;
			end
		end
		// Between slots the core rests
		s_d.sched.low_power = active && !s_d.sched.work_start;
		if (!active) begin
			s_d.sched = '0;
			s_d.sched.low_power = 1'b1;
		end

		// Wake from sleep on current flow or fault
		case (s_q.mode)
			bps_pkg::BPS_SLEEP: begin
				if ((sense_valid && sense_current != 16'sh0000) || fault_detected)
					s_d.mode = bps_pkg::BPS_NORMAL;
			end
			bps_pkg::BPS_NORMAL: ;
			bps_pkg::BPS_SHUTDOWN: ;
			default: s_d.mode = bps_pkg::BPS_NORMAL;
		endcase

		// Emergency off and its recovery
		if (!s_q.eoff) begin
			s_d.eoff_cnt = 16'h0000;
			if (btn_fall)
				s_d.eoff = 1'b1;
		end else if (btn_fall) begin
			s_d.eoff = 1'b0;
		end else if (sec_tick) begin
			if (s_q.eoff_cnt + 16'h0001 >= s_q.eoff_tmo)
				s_d.eoff = 1'b0;
			else
				s_d.eoff_cnt = s_q.eoff_cnt + 16'h0001;
		end

		// Bus off: both lines low for the full time
		if (s_q.bclk_s[1] || s_q.bdat_s[1]) begin
			s_d.busoff_cnt = 11'h000;
			s_d.busoff = 1'b0;
		end else if (tick && !s_q.busoff) begin
			if (s_q.busoff_cnt == 11'(`BPS_BUSOFF_MS - 1))
				s_d.busoff = 1'b1;
			else
				s_d.busoff_cnt = s_q.busoff_cnt + 11'h001;
		end

		// Current direction and charge integration
		if (sense_valid && active) begin
			s_d.charging = (sense_current > 16'sh0000);
			s_d.discharging = (sense_current < 16'sh0000);
			s_d.coul = s_q.coul + 32'(sense_current);
		end

		// Trip flag; set wins over clear if thresholds overlap
		if (remaining_charge <= s_q.trip_set)
			s_d.trip = 1'b1;
		else if (remaining_charge >= s_q.trip_clr)
			s_d.trip = 1'b0;

		// Fuse latches until reset: the pack is dead anyway
		if (secondary_fault)
			s_d.fuse = 1'b1;

		// Display shows fail code over capacity
		if (permanent_fail)
			s_d.seg = permanent_fail_code & bps_bar(7'd100, seg_n);
		else
			s_d.seg = bps_bar(relative_charge_percent, seg_n);
		if (!active)
			s_d.seg = 5'h00;

		// Register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				`BPS_REG_CTRL: begin
					s_d.ctrl = bus_req.wdata;
					if (bus_req.wdata[`BPS_CTRL_MODE_LSB +: 2] != 2'b11)
						s_d.mode = bps_pkg::bps_mode_type'(bus_req.wdata[`BPS_CTRL_MODE_LSB +: 2]);
				end
				`BPS_REG_SLEEP_INT: s_d.sleep_int = bus_req.wdata;
				`BPS_REG_EOFF_TMO:  s_d.eoff_tmo = bus_req.wdata;
				`BPS_REG_TRIP_SET:  s_d.trip_set = bus_req.wdata;
				`BPS_REG_TRIP_CLR:  s_d.trip_clr = bus_req.wdata;
				`BPS_REG_BALANCE:   s_d.bal_req = bus_req.wdata[3:0];
				`BPS_REG_TEMP_CFG:  s_d.temp_cfg = bus_req.wdata;
				default: ;
			endcase
		end

		// Register reads, data stand one cycle later only
		s_d.rdata = 16'h0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`BPS_REG_CTRL:      s_d.rdata = s_q.ctrl;
				`BPS_REG_STATUS:    s_d.rdata = {8'h00, s_q.discharging, s_q.charging,
					s_q.fuse, s_q.busoff, s_q.eoff, s_q.present, s_q.mode};
				`BPS_REG_SLEEP_INT: s_d.rdata = s_q.sleep_int;
				`BPS_REG_EOFF_TMO:  s_d.rdata = s_q.eoff_tmo;
				`BPS_REG_TRIP_SET:  s_d.rdata = s_q.trip_set;
				`BPS_REG_TRIP_CLR:  s_d.rdata = s_q.trip_clr;
				`BPS_REG_OP_STATE:  s_d.rdata = {15'h0000, s_q.trip};
				`BPS_REG_BALANCE:   s_d.rdata = {12'h000, s_q.bal_req};
				`BPS_REG_TEMP_CFG:  s_d.rdata = s_q.temp_cfg;
				`BPS_REG_COUL_LO:   s_d.rdata = s_q.coul[15:0];
				`BPS_REG_COUL_HI:   s_d.rdata = s_q.coul[31:16];
				default:            s_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_q            <= '0;
			s_q.system_present_n_s     <= 2'h3;
			s_q.btn_s      <= 2'h3;
			s_q.bclk_s     <= 2'h3;
			s_q.bdat_s     <= 2'h3;
			s_q.btn_stable <= 1'b1;
			s_q.mode       <= bps_pkg::BPS_NORMAL;
			s_q.ctrl       <= `BPS_CTRL_RESET;
			s_q.sleep_int  <= `BPS_SLEEP_RESET;
			s_q.eoff_tmo   <= `BPS_EOFF_RESET;
			s_q.trip_set   <= `BPS_TRIP_SET_RESET;
			s_q.trip_clr   <= `BPS_TRIP_CLR_RESET;
			s_q.temp_cfg   <= `BPS_TEMP_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Switches follow software enables unless off, fused or shut down
	assign charge_switch_drive    = s_q.ctrl[`BPS_CTRL_CHG_BIT] && !s_q.eoff
		&& !s_q.fuse && active;
	assign discharge_switch_drive = s_q.ctrl[`BPS_CTRL_DSG_BIT] && !s_q.eoff
		&& !s_q.fuse && active;
	assign trip_point_irq       = s_q.trip && s_q.ctrl[`BPS_CTRL_TRIP_BIT];
	assign trip_point_pullup_en = s_q.ctrl[`BPS_CTRL_TRIP_BIT];
	assign fuse_fire   = s_q.fuse;
	assign display_seg = s_q.seg;
	assign sched       = s_q.sched;
	assign bus_rdata   = s_q.rdata;
	// Released bus-off clears within three cycles, well inside 1 ms
	assign bus_ready   = !s_q.busoff && active;
	// External bypass allows one cell; none while discharging
	assign balance_en  = s_q.discharging || !active ? 4'h0 :
		(s_q.ctrl[`BPS_CTRL_EXTBAL_BIT] ? bps_lowest(s_q.bal_req) : s_q.bal_req);
	assign temp_enable    = s_q.temp_cfg[4:0];
	assign temp_is_switch = s_q.temp_cfg[12:8];

endmodule : bps_supervisor

`default_nettype wire

// ### tb/bps_host_model.sv
// Purpose: Host side of the two-wire bus
// Assumes: Lines are pulled up when released
// Notes:   Clock line lets go one cycle before data
`timescale 1ns/1ps
`default_nettype none
module bps_host_model (
	// Clock and control
	input  wire logic core_clk,
	input  wire logic hold_off,
	// Bus lines
	output logic      bus_clock_pin,
	output logic      bus_data_pin
);
	logic lag = 1'b0;
	always @(posedge core_clk) lag <= hold_off;
	// Exit by one line first, as a real host may
	assign bus_clock_pin = !hold_off;
	assign bus_data_pin  = !(hold_off || lag);
endmodule : bps_host_model
`default_nettype wire

// ### tb/bps_supervisor_asserts.sv
// Purpose: Port checks for bps_supervisor
// Assumes: Bound into the top module
// Notes:   Shutdown seen as bus not ready with lines up
`include "bps_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bps_chk #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic                   core_clk,
	input wire logic                   nrst,
	input wire bps_pkg::bps_bus_req_type bus_req,
	input wire logic                   bus_clock_pin,
	input wire logic                   bus_data_pin,
	input wire logic                   charge_switch_drive,
	input wire logic                   discharge_switch_drive,
	input wire logic                   trip_point_irq,
	input wire logic                   trip_point_pullup_en,
	input wire logic                   fuse_fire,
	input wire logic                   secondary_fault,
	input wire bps_pkg::bps_sched_type sched,
	input wire logic                   bus_ready
);
	int   lowcnt;
	int   hicnt;
	int   wcnt;
	logic seen;
	logic quiet;
	// Period check only while software last chose normal mode
	logic norm;
	// Margin of 20 cycles keeps bus-off exit apart from shutdown
	assign quiet = !bus_ready && hicnt > 20;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lowcnt <= 0;
			hicnt  <= 0;
			wcnt   <= 0;
			seen   <= 1'b0;
			norm   <= 1'b1;
		end else begin
			norm   <= (bus_req.wr && bus_req.addr == `BPS_REG_CTRL) ?
				(bus_req.wdata[`BPS_CTRL_MODE_LSB +: 2] == 2'b00) : norm;
			lowcnt <= (bus_clock_pin || bus_data_pin) ? 0 : lowcnt + 1;
			hicnt  <= (bus_clock_pin || bus_data_pin) ? hicnt + 1 : 0;
			wcnt   <= sched.work_start ? 0 : wcnt + 1;
			seen   <= (sched.work_start || seen) && !quiet && norm;
		end
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	busoff_delay_a: assert property (
		!bus_ready && lowcnt > 0 |-> lowcnt >= 1999 * TICK_CYCLES)
		else $error("bus off too early");
	bus_resume_a: assert property (
		$rose(bus_clock_pin || bus_data_pin) |-> ##[1:10] bus_ready)
		else $error("bus not back in time");
	low_power_a: assert property (
		sched.work_start |-> !sched.low_power ##1 sched.low_power)
		else $error("power state wrong around work");
	work_period_a: assert property (
		sched.work_start && seen |-> wcnt == 250 * TICK_CYCLES - 1)
		else $error("work period wrong");
	shut_quiet_a: assert property (
		quiet [*2] |-> !sched.work_start && !charge_switch_drive && !discharge_switch_drive)
		else $error("activity in shutdown");
	fuse_set_a: assert property (
		secondary_fault |-> ##[1:2] fuse_fire)
		else $error("fuse not fired");
	fuse_hold_a: assert property (
		fuse_fire |=> fuse_fire && !charge_switch_drive && !discharge_switch_drive)
		else $error("fuse dropped or switch on");
	pullup_a: assert property (
		trip_point_irq |-> trip_point_pullup_en)
		else $error("irq without pull-up");
	cover property (sched.work_start && seen);
	cover property (quiet);
	cover property (fuse_fire);
	cover property (sched.work_start && !norm);
endmodule : bps_chk
bind bps_supervisor bps_chk #(.TICK_CYCLES(TICK_CYCLES)) u_bps_chk (
	.core_clk, .nrst, .bus_req, .bus_clock_pin, .bus_data_pin, .charge_switch_drive,
	.discharge_switch_drive, .trip_point_irq, .trip_point_pullup_en, .fuse_fire,
	.secondary_fault, .sched, .bus_ready
);
`default_nettype wire

// ### tb/bps_supervisor_tb_top.sv
// Purpose: Self-checking bench for bps_supervisor
// Assumes: Tick cut to 10 cycles to keep runs short
// Notes:   Fuse runs last because it is sticky
`include "bps_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bps_supervisor_tb_top;
	localparam int TK = 10;
	logic                     core_clk = 1'b0;
	logic                     nrst = 1'b0;
	bps_pkg::bps_bus_req_type bus_req = '0;
	logic                     system_present_n = 1'b0;
	logic                     emergency_off_button = 1'b1;
	logic                     hold_off = 1'b0;
	logic signed [15:0]       sense_current = 16'h0000;
	logic                     sense_valid = 1'b0;
	logic [15:0]              remaining_charge = 16'h01f4;
	logic [6:0]               relative_charge_percent = 7'h64;
	logic                     permanent_fail = 1'b0;
	logic [4:0]               permanent_fail_code = 5'h00;
	logic                     secondary_fault = 1'b0;
	logic                     fault_detected = 1'b0;
	logic [15:0]              log_ram_sig = 16'h0000;
	logic [15:0]              bus_rdata;
	logic [4:0]               display_seg;
	logic [3:0]               balance_en;
	logic [4:0]               temp_enable, temp_is_switch;
	logic                     bus_clock_pin, bus_data_pin, bus_ready, fuse_fire;
	logic                     charge_switch_drive, discharge_switch_drive;
	logic                     trip_point_irq, trip_point_pullup_en;
	bps_pkg::bps_sched_type   sched;
	logic [1:0]               drv;
	int                       fail_count = 0;
	int                       n_tests = 0;
	assign drv = {charge_switch_drive, discharge_switch_drive};
	bps_host_model u_bps_host_model (.core_clk, .hold_off, .bus_clock_pin, .bus_data_pin);
	bps_supervisor #(.TICK_CYCLES(TK)) u_bps_supervisor (
		.core_clk, .nrst, .bus_req, .bus_rdata, .system_present_n, .emergency_off_button,
		.bus_clock_pin, .bus_data_pin, .charge_switch_drive, .discharge_switch_drive,
		.trip_point_irq, .trip_point_pullup_en, .fuse_fire, .display_seg, .sense_current,
		.sense_valid, .remaining_charge, .relative_charge_percent, .permanent_fail,
		.permanent_fail_code, .fault_detected, .secondary_fault, .log_ram_sig,
		.log_nv_sig(16'h0000), .log_fast_ram_sig(16'h0000), .log_fast_nv_sig(16'h0000),
		.sched, .bus_ready, .balance_en, .temp_enable, .temp_is_switch
	);
	task automatic results();
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge core_clk);
		bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge core_clk);
		bus_req <= '0;
		#1 v = bus_rdata;
	endtask : rd
	task automatic press(input logic l);
		@(posedge core_clk);
		emergency_off_button <= l;
	endtask : press
	task automatic pulse(input logic [15:0] c, input int n);
		@(posedge core_clk);
		sense_current <= c;
		sense_valid <= 1'b1;
		repeat (n) @(posedge core_clk);
		sense_valid <= 1'b0;
	endtask : pulse
	// Bounded wait for a pulse on one schedule bit
	task automatic gap(input int b, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (sched[b] !== 1'b1 && n < 6000);
	endtask : gap
	task automatic t_regs();
		logic [15:0] v;
		rd(`BPS_REG_TRIP_SET, v);
		chk(v, `BPS_TRIP_SET_RESET, "trip set reset");
		rd(8'h3c, v);
		chk(v, 16'h0000, "unmapped read");
	endtask : t_regs
	task automatic t_eoff();
		int i;
		press(1'b0);
		cyc(3);
		press(1'b1);
		cyc(3);
		press(1'b0);
		cyc(5 * TK);
		chk(16'(drv), 16'h0003, "off before debounce");
		cyc(10 * TK);
		chk(16'(drv), 16'h0000, "not off");
		press(1'b1);
		cyc(20 * TK);
		chk(16'(drv), 16'h0000, "release turned on");
		press(1'b0);
		cyc(15 * TK);
		chk(16'(drv), 16'h0003, "second press");
		press(1'b1);
		wr(`BPS_REG_EOFF_TMO, 16'h0001);
		cyc(20 * TK);
		press(1'b0);
		cyc(15 * TK);
		chk(16'(drv), 16'h0000, "not off again");
		i = 0;
		while (drv !== 2'b11 && i < 2100) begin
			cyc(TK);
			i++;
		end
		chk(16'(drv), 16'h0003, "no timeout");
		press(1'b1);
	endtask : t_eoff
	task automatic t_trip();
		logic [15:0] v;
		@(posedge core_clk);
		remaining_charge <= 16'h0064;
		wr(`BPS_REG_CTRL, 16'h032c);
		cyc(260 * TK);
		rd(`BPS_REG_OP_STATE, v);
		chk(v, 16'h0001, "trip flag");
		chk(16'({trip_point_irq, trip_point_pullup_en}), 16'h0003, "irq on");
		@(posedge core_clk);
		remaining_charge <= 16'h0190;
		cyc(260 * TK);
		chk(16'({trip_point_irq, trip_point_pullup_en}), 16'h0001, "irq off");
		wr(`BPS_REG_CTRL, `BPS_CTRL_RESET);
		cyc(2);
		chk(16'(trip_point_pullup_en), 16'h0000, "pull-up");
	endtask : t_trip
	task automatic t_coul();
		logic [15:0] a;
		logic [15:0] b;
		rd(`BPS_REG_COUL_LO, a);
		pulse(16'h0005, 3);
		log_ram_sig <= 16'h0001;
		cyc(2);
		rd(`BPS_REG_STATUS, b);
		chk(b & 16'h00c4, 16'h0044, "charge or present");
		pulse(16'hfffe, 1);
		cyc(2);
		rd(`BPS_REG_STATUS, b);
		chk(b & 16'h00c0, 16'h0080, "discharge");
		rd(`BPS_REG_COUL_LO, b);
		chk(b - a, 16'h000d, "count sum");
	endtask : t_coul
	task automatic t_cfg();
		logic [15:0] v;
		int n;
		wr(`BPS_REG_BALANCE, 16'h000b);
		wr(`BPS_REG_TEMP_CFG, 16'h1f05);
		cyc(1);
		chk(16'(balance_en), 16'h0000, "balance in discharge");
		chk(16'({temp_is_switch, temp_enable}), 16'h03e5, "temp cfg");
		wr(`BPS_REG_SLEEP_INT, 16'h0002);
		wr(`BPS_REG_CTRL, 16'h030d);
		gap(4, n);
		gap(4, n);
		chk(16'(n), 16'(500 * TK), "sleep gap");
		pulse(16'h0001, 1);
		cyc(2);
		rd(`BPS_REG_STATUS, v);
		chk(v & 16'h00c3, 16'h0040, "wake or charge");
		chk(16'(balance_en), 16'h000b, "balance all");
		wr(`BPS_REG_CTRL, 16'h031c);
		cyc(1);
		chk(16'(balance_en), 16'h0001, "balance one");
		wr(`BPS_REG_CTRL, `BPS_CTRL_RESET);
	endtask : t_cfg
	task automatic t_bus();
		logic [15:0] v;
		@(posedge core_clk);
		hold_off <= 1'b1;
		system_present_n <= 1'b1;
		cyc(1990 * TK);
		chk(16'(bus_ready), 16'h0001, "bus off early");
		cyc(20 * TK);
		chk(16'(bus_ready), 16'h0000, "no bus off");
		@(posedge core_clk);
		hold_off <= 1'b0;
		cyc(TK);
		chk(16'(bus_ready), 16'h0001, "no resume");
		rd(`BPS_REG_STATUS, v);
		chk(v & 16'h0014, 16'h0000, "absent or bus off");
	endtask : t_bus
	task automatic t_work();
		int n;
		gap(4, n);
		gap(4, n);
		chk(16'(n), 16'(250 * TK), "work gap");
		gap(3, n);
		gap(3, n);
		chk(16'(n), 16'(250 * TK), "cell gap");
		chk(16'(display_seg), 16'h0007, "bar");
		wr(`BPS_REG_CTRL, 16'h030e);
		cyc(2);
		chk(16'({drv, bus_ready}), 16'h0000, "shutdown");
		gap(4, n);
		chk(16'(n), 16'h1770, "work in shutdown");
		wr(`BPS_REG_CTRL, `BPS_CTRL_RESET);
	endtask : t_work
	task automatic t_fuse();
		@(posedge core_clk);
		permanent_fail <= 1'b1;
		permanent_fail_code <= 5'h15;
		secondary_fault <= 1'b1;
		@(posedge core_clk);
		secondary_fault <= 1'b0;
		cyc(3);
		chk(16'({fuse_fire, drv}), 16'h0004, "fuse");
		cyc(260 * TK);
		chk(16'(display_seg), 16'h0005, "fail code");
	endtask : t_fuse
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#4500000;
		fail_count++;
		results();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		t_regs();
		t_eoff();
		t_trip();
		t_coul();
		t_cfg();
		t_bus();
		t_work();
		t_fuse();
		results();
	end
endmodule : bps_supervisor_tb_top
`default_nettype wire
